//--- port_switch_regs.vh
// Register offsets, field positions, reset values and timing counts.
`ifndef PORT_SWITCH_REGS_VH
`define PORT_SWITCH_REGS_VH

// Register offsets.
`define REG_DEVICE_ID      8'h01
`define REG_CONTROL        8'h02
`define REG_INTERRUPT      8'h03
`define REG_STATUS         8'h04
`define REG_MANUAL_SWITCH_SETTING      8'h05

// Control register fields.
`define CTRL_INT_MASK      0
`define CTRL_MAN_SW_EN     2
`define CTRL_SOFT_RESET    6
`define CTRL_RESET_VAL     8'h05

// Manual switch register fields and codes.
`define MAN_PATH_LSB       0
`define MAN_PATH_MSB       1
`define MAN_FET            7
`define MAN_RESET_VAL      8'h81
`define PATH_OPEN          2'h0
`define PATH_HOST_A        2'h1
`define PATH_HOST_B        2'h2
`define PATH_AUDIO         2'h3

// Interrupt register bits.
`define INT_ID_CHANGE      0
`define INT_VBUS_CHANGE    1
`define INT_ATTACH_CHANGE  2
`define INT_BUTTON         3

// Bus-held-low reset time in ms and clock rate in kHz.
`define BUS_RESET_MS       30
`define CLK_KHZ            100000
`define BUS_RESET_CYCLES   (`BUS_RESET_MS * `CLK_KHZ)

`endif

//--- usb_port_switch_control.v
// Control logic of a USB-port accessory switch with an I2C slave.
`timescale 1ns/1ns
`default_nettype none
`include "port_switch_regs.vh"

module usb_port_switch_control #(
    parameter [6:0]  SLAVE_ADDR       = 7'h25,
    parameter [7:0]  DEVICE_ID        = 8'h5a,
    parameter [31:0] BUS_RESET_CYCLES = `BUS_RESET_CYCLES
) (
    // Clock and reset
    input  wire        core_clk,
    input  wire        rst_b,
    // I2C pins
    input  wire        i2c_scl_in,
    input  wire        i2c_sda_in,
    output wire        i2c_sda_out,
    output reg         i2c_sda_oe,
    // Detection inputs from the analog front end
    input  wire        id_resistor_present,
    input  wire        vbus_valid,
    input  wire        charger_detected,
    input  wire        button_pressed,
    // Switch controls
    output reg         sw_host_a,
    output reg         sw_host_b,
    output reg         sw_audio,
    output reg         sw_vbus_fet,
    // Charger detect open-drain pin and interrupt
    output wire        charger_attached_n_out,
    output reg         charger_attached_n_oe,
    output reg         irq_n
);

    localparam [2:0] ST_IDLE    = 3'h0;
    localparam [2:0] ST_ADDR    = 3'h1;
    localparam [2:0] ST_ACK_OUT = 3'h2;
    localparam [2:0] ST_RX      = 3'h3;
    localparam [2:0] ST_TX      = 3'h4;
    localparam [2:0] ST_ACK_IN  = 3'h5;

    // Every pin input except rst_b passes two flip-flops before any logic looks at it.
    reg  [5:0]  meta_reg;
    reg  [5:0]  sync_reg;
    wire        scl_s  = sync_reg[0];
    wire        sda_s  = sync_reg[1];
    wire        id_s   = sync_reg[2];
    wire        vbus_s = sync_reg[3];
    wire        chg_s  = sync_reg[4];
    wire        btn_s  = sync_reg[5];

    reg         scl_d_reg;
    reg         sda_d_reg;
    reg  [31:0] low_cnt_reg;
    reg         bus_rst_reg;
    wire        hw_rst = ~rst_b | bus_rst_reg;

    reg  [2:0]  state_reg;
    reg  [3:0]  bit_cnt_reg;
    reg  [7:0]  shift_reg;
    reg  [7:0]  tx_reg;
    reg  [7:0]  ptr_reg;
    reg         ptr_got_reg;
    reg         rw_reg;

    reg  [7:0]  ctrl_reg;
    reg  [7:0]  man_reg;
    reg  [3:0]  int_reg;
    reg  [3:0]  int_next;
    reg         soft_rst_reg;
    reg         id_d_reg;
    reg         vbus_d_reg;
    reg         att_d_reg;
    reg         btn_d_reg;
    reg  [7:0]  rdata;
    reg  [1:0]  path;
    reg         fet_req;

    wire scl_rise = scl_s & ~scl_d_reg;
    wire scl_fall = ~scl_s & scl_d_reg;
    wire start    = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
    wire stop     = scl_s & scl_d_reg & ~sda_d_reg & sda_s;
    // A USB accessory shows either its ID resistor or bus voltage.
    wire attached = id_s | vbus_s;
    wire wr_en    = (state_reg == ST_RX) & scl_fall & (bit_cnt_reg == 4'h8)
                    & ptr_got_reg;
    wire rd_load  = (state_reg == ST_ACK_OUT) & scl_fall & rw_reg;
    wire rd_clr   = rd_load & (ptr_reg == `REG_INTERRUPT);

    assign i2c_sda_out            = 1'b0;
    assign charger_attached_n_out = 1'b0;

    always @(posedge core_clk) begin
        if (!rst_b) begin
            meta_reg <= 6'h03;
            sync_reg <= 6'h03;
        end else begin
            meta_reg <= {button_pressed, charger_detected, vbus_valid,
                         id_resistor_present, i2c_sda_in, i2c_scl_in};
            sync_reg <= meta_reg;
        end
    end

    // The bus-low watchdog sits only under the pin reset, so it can
    // release itself after one reset cycle instead of holding itself in reset.
    always @(posedge core_clk) begin
        if (!rst_b) begin
            low_cnt_reg <= 32'h0;
            bus_rst_reg <= 1'b0;
        end else if (!scl_s && !sda_s) begin
            if (low_cnt_reg == BUS_RESET_CYCLES - 32'h1) begin
                bus_rst_reg <= 1'b1;
                low_cnt_reg <= 32'h0;
            end else begin
                bus_rst_reg <= 1'b0;
                low_cnt_reg <= low_cnt_reg + 32'h1;
            end
        end else begin
            bus_rst_reg <= 1'b0;
            low_cnt_reg <= 32'h0;
        end
    end

    always @* begin
        case (ptr_reg)
            `REG_DEVICE_ID: rdata = DEVICE_ID;
            `REG_CONTROL:   rdata = ctrl_reg;
            `REG_INTERRUPT: rdata = {4'h0, int_reg};
            `REG_STATUS:    rdata = {4'h0, btn_s, chg_s, vbus_s, id_s};
            `REG_MANUAL_SWITCH_SETTING: rdata = man_reg;
            default:        rdata = 8'h00;
        endcase
    end

    // I2C slave: bits are taken on SCL rising, SDA changes on SCL falling.
    always @(posedge core_clk) begin
        if (hw_rst) begin
            scl_d_reg   <= 1'b1;
            sda_d_reg   <= 1'b1;
            state_reg   <= ST_IDLE;
            bit_cnt_reg <= 4'h0;
            shift_reg   <= 8'h00;
            tx_reg      <= 8'h00;
            ptr_reg     <= 8'h00;
            ptr_got_reg <= 1'b0;
            rw_reg      <= 1'b0;
            i2c_sda_oe  <= 1'b0;
        end else begin
            scl_d_reg <= scl_s;
            sda_d_reg <= sda_s;
            if (start) begin
                state_reg   <= ST_ADDR;
                bit_cnt_reg <= 4'h0;
                ptr_got_reg <= 1'b0;
                i2c_sda_oe  <= 1'b0;
            end else if (stop) begin
                state_reg  <= ST_IDLE;
                i2c_sda_oe <= 1'b0;
            end else begin
                case (state_reg)
                    ST_ADDR, ST_RX: begin
                        if (scl_rise) begin
                            shift_reg   <= {shift_reg[6:0], sda_s};
                            bit_cnt_reg <= bit_cnt_reg + 4'h1;
                        end else if (scl_fall && bit_cnt_reg == 4'h8) begin
                            if (state_reg == ST_ADDR) begin
                                if (shift_reg[7:1] == SLAVE_ADDR) begin
                                    rw_reg     <= shift_reg[0];
                                    i2c_sda_oe <= 1'b1;
                                    state_reg  <= ST_ACK_OUT;
                                end else begin
                                    state_reg <= ST_IDLE;
                                end
                            end else begin
                                if (!ptr_got_reg) begin
                                    ptr_reg     <= shift_reg;
                                    ptr_got_reg <= 1'b1;
                                end else begin
                                    ptr_reg <= ptr_reg + 8'h01;
                                end
                                i2c_sda_oe <= 1'b1;
                                state_reg  <= ST_ACK_OUT;
                            end
                        end
                    end
                    ST_ACK_OUT: begin
                        if (scl_fall) begin
                            bit_cnt_reg <= 4'h0;
                            if (rw_reg) begin
                                tx_reg     <= {rdata[6:0], 1'b0};
                                i2c_sda_oe <= ~rdata[7];
                                ptr_reg    <= ptr_reg + 8'h01;
                                state_reg  <= ST_TX;
                            end else begin
                                i2c_sda_oe <= 1'b0;
                                state_reg  <= ST_RX;
                            end
                        end
                    end
                    ST_TX: begin
                        if (scl_rise) begin
                            bit_cnt_reg <= bit_cnt_reg + 4'h1;
                        end else if (scl_fall) begin
                            if (bit_cnt_reg == 4'h8) begin
                                i2c_sda_oe <= 1'b0;
                                state_reg  <= ST_ACK_IN;
                            end else begin
                                i2c_sda_oe <= ~tx_reg[7];
                                tx_reg     <= {tx_reg[6:0], 1'b0};
                            end
                        end
                    end
                    ST_ACK_IN: begin
                        // A master NACK ends the read; wait for the stop.
                        if (scl_rise) begin
                            state_reg <= sda_s ? ST_IDLE : ST_ACK_OUT;
                        end
                    end
                    default: begin
                        i2c_sda_oe <= 1'b0;
                    end
                endcase
            end
        end
    end

    // Control and manual registers survive a software reset.
    always @(posedge core_clk) begin
        if (hw_rst) begin
            ctrl_reg     <= `CTRL_RESET_VAL;
            man_reg      <= `MAN_RESET_VAL;
            soft_rst_reg <= 1'b0;
        end else begin
            soft_rst_reg <= 1'b0;
            if (wr_en && ptr_reg == `REG_CONTROL) begin
                ctrl_reg <= shift_reg & ~(8'h01 << `CTRL_SOFT_RESET);
                soft_rst_reg <= shift_reg[`CTRL_SOFT_RESET];
            end
            if (wr_en && ptr_reg == `REG_MANUAL_SWITCH_SETTING) begin
                man_reg <= shift_reg;
            end
        end
    end

    // A new event in the same cycle as the read-clear is kept.
    always @* begin
        int_next = rd_clr ? 4'h0 : int_reg;
        if (id_s != id_d_reg)
            int_next[`INT_ID_CHANGE] = 1'b1;
        if (vbus_s != vbus_d_reg)
            int_next[`INT_VBUS_CHANGE] = 1'b1;
        if (attached != att_d_reg)
            int_next[`INT_ATTACH_CHANGE] = 1'b1;
        if (btn_s && !btn_d_reg && id_s)
            int_next[`INT_BUTTON] = 1'b1;
    end

    always @(posedge core_clk) begin
        if (hw_rst) begin
            int_reg    <= 4'h0;
            id_d_reg   <= 1'b0;
            vbus_d_reg <= 1'b0;
            att_d_reg  <= 1'b0;
            btn_d_reg  <= 1'b0;
            irq_n      <= 1'b1;
        end else if (soft_rst_reg) begin
            // A soft reset keeps the pin history, so no false event follows.
            int_reg    <= 4'h0;
            id_d_reg   <= id_s;
            vbus_d_reg <= vbus_s;
            att_d_reg  <= attached;
            btn_d_reg  <= btn_s;
            irq_n      <= 1'b1;
        end else begin
            int_reg    <= int_next;
            id_d_reg   <= id_s;
            vbus_d_reg <= vbus_s;
            att_d_reg  <= attached;
            btn_d_reg  <= btn_s;
            irq_n <= ~((|int_next) & ~ctrl_reg[`CTRL_INT_MASK]);
        end
    end

    // Without manual switching the default routes an attached USB
    // accessory to host A and requests the FET.
    always @* begin
        if (ctrl_reg[`CTRL_MAN_SW_EN]) begin
            path    = man_reg[`MAN_PATH_MSB:`MAN_PATH_LSB];
            fet_req = man_reg[`MAN_FET];
        end else begin
            path    = `PATH_HOST_A;
            fet_req = 1'b1;
        end
    end

    // Each path code drives at most one switch, so D+ and D- never reach two ports.
    always @(posedge core_clk) begin
        if (hw_rst) begin
            sw_host_a             <= 1'b0;
            sw_host_b             <= 1'b0;
            sw_audio              <= 1'b0;
            sw_vbus_fet           <= 1'b0;
            charger_attached_n_oe <= 1'b0;
        end else begin
            sw_host_a <= attached & (path == `PATH_HOST_A);
            sw_host_b <= attached & (path == `PATH_HOST_B);
            sw_audio    <= attached & (path == `PATH_AUDIO);
            sw_vbus_fet <= attached & vbus_s & fet_req;
            charger_attached_n_oe <= chg_s;
        end
    end

endmodule // usb_port_switch_control
`default_nettype wire

//--- usb_port_switch_control_properties.sv
// Concurrent checks on the pins of the port switch control block.
`timescale 1ns/1ns
`default_nettype none
module usb_port_switch_control_checker (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // Bus and detection inputs
    input wire logic i2c_scl_in,
    input wire logic id_resistor_present,
    input wire logic vbus_valid,
    input wire logic charger_detected,
    // Outputs under watch
    input wire logic i2c_sda_oe,
    input wire logic sw_host_a,
    input wire logic sw_host_b,
    input wire logic sw_audio,
    input wire logic sw_vbus_fet,
    input wire logic charger_attached_n_oe,
    input wire logic irq_n
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    // Five quiet cycles cover the two-stage synchroniser and the output flop.
    a_fet_needs_vbus: assert property (
        (!vbus_valid) [*5] |=> !sw_vbus_fet) else $error("fet without vbus");
    a_detach_all_open: assert property (
        (!id_resistor_present && !vbus_valid) [*5] |=>
        !(sw_host_a || sw_host_b || sw_audio || sw_vbus_fet))
        else $error("switch closed while detached");
    a_one_data_path: assert property (
        $onehot0({sw_host_a, sw_host_b, sw_audio})) else $error("two paths");
    a_charger_pulls_low: assert property (
        charger_detected [*5] |=> charger_attached_n_oe)
        else $error("charger pin not pulled");
    a_charger_floats: assert property (
        (!charger_detected) [*5] |=> !charger_attached_n_oe)
        else $error("charger pin pulled with no charger");
    a_reset_quiet: assert property (
        $rose(rst_b) |-> irq_n && !sw_host_a && !sw_vbus_fet && !i2c_sda_oe)
        else $error("outputs active at reset release");
    a_irq_masked_reset: assert property (
        $rose(rst_b) |-> irq_n [*8]) else $error("interrupt not masked");
    a_irq_holds_low: assert property (
        $fell(irq_n) |-> (!irq_n) [*8]) else $error("interrupt dropped early");
    a_sda_drive_clock_low: assert property (
        $rose(i2c_sda_oe) |-> !i2c_scl_in) else $error("sda driven in high");
    c_host_b: cover property (sw_host_b);
    c_audio: cover property (sw_audio);
    c_irq: cover property ($fell(irq_n));
endmodule // usb_port_switch_control_checker
bind usb_port_switch_control usb_port_switch_control_checker u_chk (
    .core_clk(core_clk), .rst_b(rst_b), .i2c_scl_in(i2c_scl_in),
    .id_resistor_present(id_resistor_present), .vbus_valid(vbus_valid),
    .charger_detected(charger_detected), .i2c_sda_oe(i2c_sda_oe),
    .sw_host_a(sw_host_a), .sw_host_b(sw_host_b), .sw_audio(sw_audio),
    .sw_vbus_fet(sw_vbus_fet), .irq_n(irq_n),
    .charger_attached_n_oe(charger_attached_n_oe));
`default_nettype wire

//--- i2c_host_model.sv
// Behavioural I2C master standing in for the baseband processor.
`timescale 1ns/1ns
`default_nettype none
module i2c_host_model #(
    parameter int HALF = 8
) (
    // Core clock for pacing
    input  wire logic core_clk,
    // Resolved data wire
    input  wire logic sda_line,
    // Pull-down drives
    output var  logic scl_low,
    output var  logic sda_low
);
    initial begin
        scl_low = 1'b0;
        sda_low = 1'b0;
    end
    task automatic wait_half;
        repeat (HALF) @(posedge core_clk);
        #1;
    endtask
    // Data changes only while the clock is low, so no false start occurs.
    task automatic put_bit(input logic b, output logic got);
        sda_low = !b;
        wait_half();
        scl_low = 1'b0;
        wait_half();
        got = sda_line;
        scl_low = 1'b1;
    endtask
    task automatic put_byte(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--)
            put_bit(tx[i], rx[i]);
    endtask
    task automatic start;
        sda_low = 1'b0;
        wait_half();
        scl_low = 1'b0;
        wait_half();
        sda_low = 1'b1;
        wait_half();
        scl_low = 1'b1;
        wait_half();
    endtask
    task automatic stop;
        sda_low = 1'b1;
        wait_half();
        scl_low = 1'b0;
        wait_half();
        sda_low = 1'b0;
        wait_half();
    endtask
    task automatic write_reg(input logic [7:0] dev, input logic [7:0] ptr,
                             input logic [7:0] data, output logic [7:0] acks);
        logic [7:0] seq [3];
        logic [7:0] junk;
        logic       a;
        seq = '{dev, ptr, data};
        acks = 8'h00;
        start();
        for (int k = 0; k < 3; k++) begin
            put_byte(seq[k], junk);
            put_bit(1'b1, a);
            acks = acks + {7'h00, !a};
        end
        stop();
    endtask
    task automatic read_reg(input logic [7:0] ptr, output logic [7:0] rd);
        logic [7:0] junk;
        logic       a;
        start();
        put_byte(8'h4a, junk);
        put_bit(1'b1, a);
        put_byte(ptr, junk);
        put_bit(1'b1, a);
        start();
        put_byte(8'h4b, junk);
        put_bit(1'b1, a);
        put_byte(8'hff, rd);
        put_bit(1'b1, a);
        stop();
    endtask
    task automatic bus_reset(input int n);
        sda_low = 1'b1;
        scl_low = 1'b1;
        repeat (n) @(posedge core_clk);
        #1;
        scl_low = 1'b0;
        wait_half();
        sda_low = 1'b0;
        wait_half();
    endtask
endmodule // i2c_host_model
`default_nettype wire

//--- usb_port_switch_control_bench.sv
// Self-checking bench for the port switch control block.
`timescale 1ns/1ns
`default_nettype none
module usb_port_switch_control_bench;
    logic       core_clk, rst_b, id_res, vbus, chg, btn, scl_low, sda_low;
    wire logic  sda_oe, sda_out, chg_out, chg_oe, irq_n;
    wire logic  sw_a, sw_b, sw_au, sw_fet;
    wire logic  scl_line = !scl_low;
    wire logic  sda_line = !(sda_low || (sda_oe && !sda_out));
    int         failures, check_count, cycles;
    logic [7:0] rd, acks;
    usb_port_switch_control #(.BUS_RESET_CYCLES(32'h32))
        u_usb_port_switch_control (
        .core_clk(core_clk), .rst_b(rst_b), .i2c_scl_in(scl_line),
        .i2c_sda_in(sda_line), .i2c_sda_out(sda_out), .i2c_sda_oe(sda_oe),
        .id_resistor_present(id_res), .vbus_valid(vbus),
        .charger_detected(chg), .button_pressed(btn), .sw_host_a(sw_a),
        .sw_host_b(sw_b), .sw_audio(sw_au), .sw_vbus_fet(sw_fet),
        .charger_attached_n_out(chg_out), .charger_attached_n_oe(chg_oe),
        .irq_n(irq_n));
    i2c_host_model u_host (.core_clk(core_clk), .sda_line(sda_line),
        .scl_low(scl_low), .sda_low(sda_low));
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = !core_clk;
    end
    task automatic conclude;
        if (failures == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %0t value %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_pins(input logic [3:0] exp);
        check_count++;
        if ({sw_a, sw_b, sw_au, sw_fet} !== exp) begin
            failures++;
            $display("CHECK FAILED %0t switches differ from %b", $time, exp);
        end
    endtask
    // Inputs are {id, vbus, charger, button}; eight cycles pass sync and flop.
    task automatic apply(input logic [3:0] v);
        @(posedge core_clk);
        #1;
        {id_res, vbus, chg, btn} = v;
        repeat (8) @(posedge core_clk);
        #1;
    endtask
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 40000) begin
            failures++;
            conclude();
        end
    end
    initial begin
        {rst_b, id_res, vbus, chg, btn} = 5'h00;
        {failures, check_count, cycles} = '0;
        repeat (12) @(posedge core_clk);
        #1;
        rst_b = 1'b1;
        apply(4'h0);
        chk_pins(4'b0000);
        chk_reg({7'h00, irq_n}, 8'h01);
        apply(4'h4);
        chk_pins(4'b1001);
        chk_reg({7'h00, irq_n}, 8'h01);
        u_host.read_reg(8'h02, rd);
        chk_reg(rd, 8'h05);
        u_host.read_reg(8'h05, rd);
        chk_reg(rd, 8'h81);
        u_host.read_reg(8'h04, rd);
        chk_reg(rd, 8'h02);
        u_host.read_reg(8'h07, rd);
        chk_reg(rd, 8'h00);
        apply(4'h8);
        chk_pins(4'b1000);
        apply(4'hc);
        for (int p = 0; p < 4; p++) begin
            u_host.write_reg(8'h4a, 8'h05, {6'h20, p[1:0]}, acks);
            chk_reg(acks, 8'h03);
            apply(4'hc);
            chk_pins({p == 1, p == 2, p == 3, 1'b1});
        end
        u_host.write_reg(8'h50, 8'h05, 8'h81, acks);
        chk_reg(acks, 8'h00);
        apply(4'he);
        chk_pins(4'b0011);
        chk_reg({7'h00, chg_oe}, 8'h01);
        chk_reg({6'h00, chg_out, sda_out}, 8'h00);
        u_host.read_reg(8'h03, rd);
        u_host.write_reg(8'h4a, 8'h02, 8'h04, acks);
        chk_reg({7'h00, irq_n}, 8'h01);
        apply(4'h8);
        chk_reg({6'h00, chg_oe, irq_n}, 8'h00);
        u_host.read_reg(8'h03, rd);
        chk_reg(rd, 8'h02);
        chk_reg({7'h00, irq_n}, 8'h01);
        apply(4'h9);
        u_host.read_reg(8'h03, rd);
        chk_reg(rd, 8'h08);
        apply(4'hc);
        chk_reg({7'h00, irq_n}, 8'h00);
        u_host.write_reg(8'h4a, 8'h02, 8'h44, acks);
        apply(4'hc);
        chk_reg({7'h00, irq_n}, 8'h01);
        u_host.read_reg(8'h03, rd);
        chk_reg(rd, 8'h00);
        u_host.read_reg(8'h02, rd);
        chk_reg(rd, 8'h04);
        u_host.bus_reset(60);
        apply(4'hc);
        chk_pins(4'b1001);
        u_host.read_reg(8'h02, rd);
        chk_reg(rd, 8'h05);
        conclude();
    end
endmodule // usb_port_switch_control_bench
`default_nettype wire
